// *** design/tri_engine.sv ***
// transfer engine driven by register-information sets held in ram
//
// Behaviour
// - size bit 0 moves bytes, 1 moves 16-bit words.
// - side bit 0 makes destination the repeat/block area, 1 the source.
// - operating mode 00 normal, 01 repeat, 10 block.
// - fixed destination stepping keeps destination address.
// - destination stepping 10 adds 1 per byte, 2 per word.
// - destination stepping 11 subtracts 1 per byte, 2 per word.
// - fixed source stepping keeps source address.
// - source stepping 10 adds 1 per byte, 2 per word.
// - source stepping 11 subtracts 1 per byte, 2 per word.
// - data read from the 24-bit source address.
// - data written to the 24-bit destination address.
// - 16-bit count A holds transfers still to do.
// - 16-bit count B holds block transfers in block mode.
// - a set is fetched only if its first word lies inside f800 to fbff.
// - engine reaches the information area with 32-bit accesses.
`timescale 1ns/100ps
`include "tri_regs.svh"

module tri_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;
   assign o_in_ready = (count != FULL);
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

module tri_engine (
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic I_START,
   input wire logic [15:0] I_INFO_ADDR,
   output logic O_BUSY,
   output logic O_FAULT,
   output logic O_IRQ,
   output logic O_RAM_REQ,
   output logic O_RAM_WE,
   output logic [15:0] O_RAM_ADDR,
   output logic [31:0] O_RAM_WDATA,
   input wire logic I_RAM_ACK,
   input wire logic [31:0] I_RAM_RDATA,
   output logic O_BUS_REQ,
   output logic O_BUS_WE,
   output logic O_BUS_WORD,
   output logic [23:0] O_BUS_ADDR,
   output logic [15:0] O_BUS_WDATA,
   input wire logic I_BUS_ACK,
   input wire logic [15:0] I_BUS_RDATA
);
   tri_pkg::tri_state_type state;
   tri_pkg::tri_state_type next_state;
   tri_pkg::tri_mode_a_type mode_a;
   tri_pkg::tri_mode_b_type mode_b;
   tri_pkg::tri_bus_req_type bus;
   logic [23:0] src;
   logic [23:0] dst;
   logic [23:0] area_start;
   logic [15:0] count_a;
   logic [15:0] count_b;
   logic [15:0] info_ptr;
   logic [8:0] rd_left;
   logic ram_ack;
   logic rd_ack;
   logic wr_ack;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic issue_rd;
   logic issue_wr;
   logic is_normal;
   logic is_repeat;
   logic is_block;
   logic count_zero;
   logic [15:0] chain_ptr;
   logic rewind;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic in_window(input logic [15:0] a);
      return a[15:10] == `TRI_WIN_TAG;
   endfunction

   function automatic logic [23:0] step(input logic [23:0] a,
                                        input logic [1:0] code,
                                        input logic word);
      logic [23:0] d;
      d = word ? `TRI_STEP_WORD : `TRI_STEP_BYTE;
      case (code)
         `TRI_STEP_INC: return a + d;
         `TRI_STEP_DEC: return a - d;
         default: return a;
      endcase
   endfunction

   assign is_normal = (mode_a.op_mode == `TRI_MODE_NORMAL);
   assign is_repeat = (mode_a.op_mode == `TRI_MODE_REPEAT);
   assign is_block = (mode_a.op_mode == `TRI_MODE_BLOCK);
   assign count_zero = is_block ? (count_b == '0) : (count_a == '0);
   assign chain_ptr = info_ptr + `TRI_SET_BYTES;
   assign rewind = (state == tri_pkg::TRI_S_ADJ) &&
                   (is_block || (is_repeat && count_a[7:0] == 8'h01));
   assign ram_ack = O_RAM_REQ && I_RAM_ACK;
   assign rd_ack = bus.req && !bus.we && I_BUS_ACK;
   assign wr_ack = bus.req && bus.we && I_BUS_ACK;
   // reads stall on a full buffer, so back-pressure holds the source side
   assign issue_rd = (state == tri_pkg::TRI_S_READ) && !bus.req &&
                     (rd_left != '0) && fifo_in_ready;
   assign issue_wr = (state == tri_pkg::TRI_S_WRITE) && !bus.req &&
                     fifo_out_valid;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         tri_pkg::TRI_S_IDLE:
            if (I_START && in_window(I_INFO_ADDR))
               next_state = tri_pkg::TRI_S_FETCH0;
         tri_pkg::TRI_S_FETCH0:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_FETCH1;
         tri_pkg::TRI_S_FETCH1:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_FETCH2;
         tri_pkg::TRI_S_FETCH2:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_READ;
         tri_pkg::TRI_S_READ:
            if (!bus.req && (rd_left == '0 || !fifo_in_ready))
               next_state = tri_pkg::TRI_S_WRITE;
         tri_pkg::TRI_S_WRITE:
            if (!bus.req && !fifo_out_valid)
               next_state = (rd_left != '0) ? tri_pkg::TRI_S_READ :
                            tri_pkg::TRI_S_ADJ;
         tri_pkg::TRI_S_ADJ:
            next_state = tri_pkg::TRI_S_WB0;
         tri_pkg::TRI_S_WB0:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_WB1;
         tri_pkg::TRI_S_WB1:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_WB2;
         tri_pkg::TRI_S_WB2:
            if (ram_ack)
               next_state = tri_pkg::TRI_S_DONE;
         tri_pkg::TRI_S_DONE:
            if (mode_b.chain_enable && in_window(chain_ptr))
               next_state = tri_pkg::TRI_S_FETCH0;
            else
               next_state = tri_pkg::TRI_S_IDLE;
         default:
            next_state = tri_pkg::TRI_S_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
         state <= tri_pkg::TRI_S_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         O_BUSY <= 1'b0;
         O_FAULT <= 1'b0;
         O_IRQ <= 1'b0;
      end
      else
      begin
         O_BUSY <= (next_state != tri_pkg::TRI_S_IDLE);
         if (state == tri_pkg::TRI_S_IDLE && I_START)
            O_FAULT <= !in_window(I_INFO_ADDR);
         else if (state == tri_pkg::TRI_S_DONE && mode_b.chain_enable)
            O_FAULT <= !in_window(chain_ptr);
         O_IRQ <= (state == tri_pkg::TRI_S_DONE) &&
                  !mode_b.chain_enable &&
                  (mode_b.interrupt_select || count_zero);
      end
   end

   // ---------------------------------------------------------------
   // information ram port, full 32-bit words
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         O_RAM_REQ <= 1'b0;
         O_RAM_WE <= 1'b0;
         O_RAM_ADDR <= `TRI_RST_PTR;
         O_RAM_WDATA <= '0;
      end
      else
      begin
         O_RAM_REQ <= 1'b1;
         O_RAM_WE <= 1'b0;
         O_RAM_WDATA <= '0;
         case (next_state)
            tri_pkg::TRI_S_FETCH0:
               O_RAM_ADDR <= (state == tri_pkg::TRI_S_DONE) ? chain_ptr :
                             (state == tri_pkg::TRI_S_IDLE) ?
                             {I_INFO_ADDR[15:2], 2'b00} : O_RAM_ADDR;
            tri_pkg::TRI_S_FETCH1:
               O_RAM_ADDR <= info_ptr + `TRI_OFS_WORD1;
            tri_pkg::TRI_S_FETCH2:
               O_RAM_ADDR <= info_ptr + `TRI_OFS_WORD2;
            tri_pkg::TRI_S_WB0:
            begin
               O_RAM_WE <= 1'b1;
               O_RAM_ADDR <= info_ptr + `TRI_OFS_WORD0;
               // the rewind lands on this same edge, so word0 must see it
               O_RAM_WDATA <= {mode_a, (rewind &&
                               mode_a.repeat_side_select) ? area_start :
                               src};
            end
            tri_pkg::TRI_S_WB1:
            begin
               O_RAM_WE <= 1'b1;
               O_RAM_ADDR <= info_ptr + `TRI_OFS_WORD1;
               O_RAM_WDATA <= {mode_b, dst};
            end
            tri_pkg::TRI_S_WB2:
            begin
               O_RAM_WE <= 1'b1;
               O_RAM_ADDR <= info_ptr + `TRI_OFS_WORD2;
               O_RAM_WDATA <= {count_a, count_b};
            end
            default:
               O_RAM_REQ <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
         info_ptr <= `TRI_RST_PTR;
      else if (state == tri_pkg::TRI_S_IDLE && I_START)
         info_ptr <= {I_INFO_ADDR[15:2], 2'b00};
      else if (state == tri_pkg::TRI_S_DONE)
         info_ptr <= chain_ptr;
   end

   // ---------------------------------------------------------------
   // fetched fields; reset clears them to zero until a fetch loads them
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         mode_a <= `TRI_RST_MODE;
         mode_b <= `TRI_RST_MODE;
      end
      else if (ram_ack && state == tri_pkg::TRI_S_FETCH0)
         mode_a <= I_RAM_RDATA[`TRI_MODE_MSB:`TRI_MODE_LSB];
      else if (ram_ack && state == tri_pkg::TRI_S_FETCH1)
         mode_b <= I_RAM_RDATA[`TRI_MODE_MSB:`TRI_MODE_LSB];
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         src <= `TRI_RST_ADDR;
         dst <= `TRI_RST_ADDR;
         area_start <= `TRI_RST_ADDR;
      end
      else
      begin
         if (ram_ack && state == tri_pkg::TRI_S_FETCH0)
            src <= I_RAM_RDATA[`TRI_ADDR_MSB:0];
         if (ram_ack && state == tri_pkg::TRI_S_FETCH1)
         begin
            dst <= I_RAM_RDATA[`TRI_ADDR_MSB:0];
            area_start <= mode_a.repeat_side_select ? src :
                          I_RAM_RDATA[`TRI_ADDR_MSB:0];
         end
         if (rd_ack)
            src <= step(src, mode_a.src_step, mode_a.size_select);
         if (wr_ack)
            dst <= step(dst, mode_a.dest_step, mode_a.size_select);
         // the area rewinds at the end of a block or a repeat run
         if (rewind)
         begin
            if (mode_a.repeat_side_select)
               src <= area_start;
            else
               dst <= area_start;
         end
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         count_a <= `TRI_RST_CNT;
         count_b <= `TRI_RST_CNT;
      end
      else if (ram_ack && state == tri_pkg::TRI_S_FETCH2)
      begin
         count_a <= I_RAM_RDATA[`TRI_CNTA_MSB:`TRI_CNTA_LSB];
         count_b <= I_RAM_RDATA[`TRI_CNTB_MSB:0];
      end
      else if (state == tri_pkg::TRI_S_ADJ)
      begin
         if (is_normal)
            count_a <= count_a - 16'h0001;
         else if (is_repeat && count_a[7:0] == 8'h01)
            count_a[7:0] <= count_a[15:8];
         else if (is_repeat)
            count_a[7:0] <= count_a[7:0] - 8'h01;
         else if (is_block)
            count_b <= count_b - 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // data moves through the buffer
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
         rd_left <= `TRI_RST_UNITS;
      else if (ram_ack && state == tri_pkg::TRI_S_FETCH2)
      begin
         // a block size of zero means a full 256-unit block
         if (mode_a.op_mode == `TRI_MODE_BLOCK)
            rd_left <= (I_RAM_RDATA[23:16] == 8'h00) ? `TRI_BLOCK_FULL :
                       {1'b0, I_RAM_RDATA[23:16]};
         else
            rd_left <= 9'h001;
      end
      else if (rd_ack)
         rd_left <= rd_left - 9'h001;
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
         bus <= '0;
      else if (I_BUS_ACK && bus.req)
         bus.req <= 1'b0;
      else if (issue_rd)
      begin
         bus.req <= 1'b1;
         bus.we <= 1'b0;
         bus.word <= mode_a.size_select;
         bus.addr <= src;
      end
      else if (issue_wr)
      begin
         bus.req <= 1'b1;
         bus.we <= 1'b1;
         bus.word <= mode_a.size_select;
         bus.addr <= dst;
         bus.wdata <= fifo_out_data;
      end
   end

   assign O_BUS_REQ = bus.req;
   assign O_BUS_WE = bus.we;
   assign O_BUS_WORD = bus.word;
   assign O_BUS_ADDR = bus.addr;
   assign O_BUS_WDATA = bus.wdata;

   tri_fifo #(
      .WIDTH(`TRI_FIFO_WIDTH),
      .DEPTH(`TRI_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_in_valid(rd_ack),
      .o_in_ready(fifo_in_ready),
      .i_in_data(I_BUS_RDATA),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(issue_wr),
      .o_out_data(fifo_out_data)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);

   a_unit_size: assert property ($rose(O_BUS_REQ) |->
      O_BUS_WORD == mode_a.size_select)
      else $error("bus unit size differs from size bit");
   a_area_rewind: assert property (state == tri_pkg::TRI_S_ADJ &&
      is_block && !mode_a.repeat_side_select |=> dst == $past(area_start))
      else $error("block area did not rewind");
   a_src_rewind: assert property (state == tri_pkg::TRI_S_ADJ &&
      is_block && mode_a.repeat_side_select |=> src == $past(area_start))
      else $error("block source area did not rewind");
   a_repeat_reload: assert property (state == tri_pkg::TRI_S_ADJ &&
      is_repeat && count_a[7:0] == 8'h01 |=>
      count_a[7:0] == $past(count_a[15:8]))
      else $error("repeat count not reloaded");
   a_dest_fixed: assert property (wr_ack && !mode_a.dest_step[1] |=>
      dst == $past(dst))
      else $error("fixed destination moved");
   a_dest_inc: assert property (wr_ack &&
      mode_a.dest_step == `TRI_STEP_INC |=> dst == $past(dst) +
      (mode_a.size_select ? `TRI_STEP_WORD : `TRI_STEP_BYTE))
      else $error("destination increment wrong");
   a_dest_dec: assert property (wr_ack &&
      mode_a.dest_step == `TRI_STEP_DEC |=> dst == $past(dst) -
      (mode_a.size_select ? `TRI_STEP_WORD : `TRI_STEP_BYTE))
      else $error("destination decrement wrong");
   a_src_fixed: assert property (rd_ack && !mode_a.src_step[1] |=>
      $stable(src))
      else $error("fixed source moved");
   a_src_inc: assert property (rd_ack &&
      mode_a.src_step == `TRI_STEP_INC |=> src == $past(src) +
      (mode_a.size_select ? `TRI_STEP_WORD : `TRI_STEP_BYTE))
      else $error("source increment wrong");
   a_src_dec: assert property (rd_ack &&
      mode_a.src_step == `TRI_STEP_DEC |=> src == $past(src) -
      (mode_a.size_select ? `TRI_STEP_WORD : `TRI_STEP_BYTE))
      else $error("source decrement wrong");
   a_read_addr: assert property ($rose(O_BUS_REQ) && !O_BUS_WE |->
      O_BUS_ADDR == src)
      else $error("read not at source address");
   a_write_addr: assert property ($rose(O_BUS_REQ) && O_BUS_WE |->
      O_BUS_ADDR == dst)
      else $error("write not at destination address");
   a_count_a_dec: assert property (state == tri_pkg::TRI_S_ADJ &&
      is_normal |=> count_a == $past(count_a) - 16'h0001)
      else $error("count a not decremented");
   a_count_b_dec: assert property (state == tri_pkg::TRI_S_ADJ &&
      is_block |=> count_b == $past(count_b) - 16'h0001)
      else $error("count b not decremented");
   a_ram_window: assert property (O_RAM_REQ |->
      O_RAM_ADDR[15:10] == `TRI_WIN_TAG)
      else $error("ram access outside information window");
   a_wb_count: assert property (O_RAM_REQ && O_RAM_WE &&
      state == tri_pkg::TRI_S_WB2 |-> O_RAM_WDATA == {count_a, count_b})
      else $error("count word written back wrong");
   a_chain_next: assert property (state == tri_pkg::TRI_S_DONE &&
      mode_b.chain_enable && in_window(chain_ptr) |=>
      state == tri_pkg::TRI_S_FETCH0 ##0 O_RAM_ADDR == $past(chain_ptr))
      else $error("chain did not fetch next set");
   a_irq_select: assert property (state == tri_pkg::TRI_S_DONE &&
      !mode_b.chain_enable && (mode_b.interrupt_select || count_zero)
      |=> O_IRQ ##1 !O_IRQ)
      else $error("interrupt request missing");

   c_normal_done: cover property (state == tri_pkg::TRI_S_DONE && is_normal);
   c_block_done: cover property (state == tri_pkg::TRI_S_DONE && is_block);
   c_chain: cover property (state == tri_pkg::TRI_S_DONE &&
      mode_b.chain_enable);
   c_fifo_full: cover property (state == tri_pkg::TRI_S_READ &&
      !fifo_in_ready);
endmodule

// *** design/tri_regs.svh ***
// offsets, field positions, codes and reset values of the transfer engine
`ifndef TRI_REGS_SVH
`define TRI_REGS_SVH
// register-information window in on-chip ram
`define TRI_INFO_BASE 16'hf800
`define TRI_INFO_LAST 16'hfbff
`define TRI_WIN_TAG 6'h3e
// word offsets of one register-information set (32-bit words)
`define TRI_OFS_WORD0 16'h0000
`define TRI_OFS_WORD1 16'h0004
`define TRI_OFS_WORD2 16'h0008
`define TRI_SET_BYTES 16'h000c
// field positions inside the fetched words
`define TRI_MODE_MSB 31
`define TRI_MODE_LSB 24
`define TRI_ADDR_MSB 23
`define TRI_CNTA_MSB 31
`define TRI_CNTA_LSB 16
`define TRI_CNTB_MSB 15
// operating modes and address stepping codes
`define TRI_MODE_NORMAL 2'b00
`define TRI_MODE_REPEAT 2'b01
`define TRI_MODE_BLOCK 2'b10
`define TRI_STEP_INC 2'b10
`define TRI_STEP_DEC 2'b11
`define TRI_STEP_BYTE 24'h000001
`define TRI_STEP_WORD 24'h000002
// data buffer shape
`define TRI_FIFO_WIDTH 16
`define TRI_FIFO_DEPTH 32
// reset values of internal state
`define TRI_RST_ADDR 24'h000000
`define TRI_RST_CNT 16'h0000
`define TRI_RST_MODE 8'h00
`define TRI_RST_PTR 16'h0000
`define TRI_RST_UNITS 9'h000
`define TRI_BLOCK_FULL 9'h100
`endif

// *** design/tri_pkg.sv ***
// types shared by the transfer engine
package tri_pkg;
   typedef struct packed
   {
      logic [1:0] src_step;
      logic [1:0] dest_step;
      logic [1:0] op_mode;
      logic repeat_side_select;
      logic size_select;
   } tri_mode_a_type;

   typedef struct packed
   {
      logic chain_enable;
      logic interrupt_select;
      logic [5:0] unused;
   } tri_mode_b_type;

   typedef struct packed
   {
      logic req;
      logic we;
      logic word;
      logic [23:0] addr;
      logic [15:0] wdata;
   } tri_bus_req_type;

   typedef enum logic [10:0]
   {
      TRI_S_IDLE = 11'h001,
      TRI_S_FETCH0 = 11'h002,
      TRI_S_FETCH1 = 11'h004,
      TRI_S_FETCH2 = 11'h008,
      TRI_S_READ = 11'h010,
      TRI_S_WRITE = 11'h020,
      TRI_S_ADJ = 11'h040,
      TRI_S_WB0 = 11'h080,
      TRI_S_WB1 = 11'h100,
      TRI_S_WB2 = 11'h200,
      TRI_S_DONE = 11'h400
   } tri_state_type;
endpackage

// *** testbench/tri_mem_model.sv ***
// memory model: info ram and data space on the far side of the engine
`timescale 1ns/100ps
module tri_mem_model (
   input wire logic i_clk,
   input wire logic i_ram_req,
   input wire logic i_ram_we,
   input wire logic [15:0] i_ram_addr,
   input wire logic [31:0] i_ram_wdata,
   output logic o_ram_ack = 1'b0,
   output logic [31:0] o_ram_rdata = 32'h0,
   input wire logic i_bus_req,
   input wire logic i_bus_we,
   input wire logic i_bus_word,
   input wire logic [23:0] i_bus_addr,
   input wire logic [15:0] i_bus_wdata,
   output logic o_bus_ack = 1'b0,
   output logic [15:0] o_bus_rdata = 16'h0
);
   logic [31:0] info [0:255];
   logic [7:0] dmem [logic [23:0]];
   int slow = 0;
   int wcnt = 0;
   int bad_addr = 0;
   // idle read data flips each cycle so a stale value never looks valid
   always @(posedge i_clk)
   begin
      o_ram_ack <= 1'b0;
      o_ram_rdata <= ~o_ram_rdata;
      if (i_ram_req && !o_ram_ack)
      begin
         if (i_ram_addr[15:10] != 6'h3e) bad_addr++;
         o_ram_ack <= 1'b1;
         if (i_ram_we) info[i_ram_addr[9:2]] <= i_ram_wdata;
         else o_ram_rdata <= info[i_ram_addr[9:2]];
      end
   end
   // slow stretches every data ack so the engine must hold its request
   always @(posedge i_clk)
   begin
      o_bus_ack <= 1'b0;
      o_bus_rdata <= ~o_bus_rdata;
      if (!i_bus_req || o_bus_ack) wcnt <= 0;
      else if (wcnt < slow) wcnt <= wcnt + 1;
      else
      begin
         o_bus_ack <= 1'b1;
         if (!i_bus_we && i_bus_word)
            o_bus_rdata <= {dmem[i_bus_addr], dmem[i_bus_addr + 24'h1]};
         else if (!i_bus_we) o_bus_rdata <= {8'h00, dmem[i_bus_addr]};
         else if (i_bus_word)
         begin
            dmem[i_bus_addr] = i_bus_wdata[15:8];
            dmem[i_bus_addr + 24'h1] = i_bus_wdata[7:0];
         end
         else dmem[i_bus_addr] = i_bus_wdata[7:0];
      end
   end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the transfer engine
`timescale 1ns/100ps
module tb_top;
   logic clk = 0, reset_n = 0, start = 0, busy, fault, irq;
   logic ram_req, ram_we, ram_ack, bus_req, bus_we, bus_word, bus_ack;
   logic [15:0] info_addr = 16'h0, ram_addr, bus_wdata, bus_rdata;
   logic [31:0] ram_wdata, ram_rdata;
   logic [23:0] bus_addr;
   int bad_count = 0, compares = 0, irq_n = 0, n0;
   logic [7:0] modes [6] = '{8'ha0, 8'hc1, 8'h30, 8'hb1, 8'he0, 8'h51};
   logic [7:0] m;
   tri_engine u_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_START(start),
      .I_INFO_ADDR(info_addr), .O_BUSY(busy), .O_FAULT(fault), .O_IRQ(irq),
      .O_RAM_REQ(ram_req), .O_RAM_WE(ram_we), .O_RAM_ADDR(ram_addr),
      .O_RAM_WDATA(ram_wdata), .I_RAM_ACK(ram_ack), .I_RAM_RDATA(ram_rdata),
      .O_BUS_REQ(bus_req), .O_BUS_WE(bus_we), .O_BUS_WORD(bus_word),
      .O_BUS_ADDR(bus_addr), .O_BUS_WDATA(bus_wdata), .I_BUS_ACK(bus_ack),
      .I_BUS_RDATA(bus_rdata));
   tri_mem_model u_mem (.i_clk(clk), .i_ram_req(ram_req), .i_ram_we(ram_we),
      .i_ram_addr(ram_addr), .i_ram_wdata(ram_wdata), .o_ram_ack(ram_ack),
      .o_ram_rdata(ram_rdata), .i_bus_req(bus_req), .i_bus_we(bus_we),
      .i_bus_word(bus_word), .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata),
      .o_bus_ack(bus_ack), .o_bus_rdata(bus_rdata));
   always #2.5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_n++;
   task automatic tally_and_finish;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [15:0] p, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] c);
      u_mem.info[p[9:2]] = a;
      u_mem.info[p[9:2] + 8'h1] = b;
      u_mem.info[p[9:2] + 8'h2] = c;
   endtask
   task automatic chk_set(input logic [15:0] p, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] c);
      check(u_mem.info[p[9:2]], a);
      check(u_mem.info[p[9:2] + 8'h1], b);
      check(u_mem.info[p[9:2] + 8'h2], c);
   endtask
   task automatic go(input logic [15:0] p);
      int n;
      n = 0;
      n0 = irq_n;
      start = 1;
      info_addr = p;
      @(negedge clk);
      start = 0;
      while (busy !== 1'b0 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 4000) check(32'h1, 32'h0);
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [23:0] nxt(input logic [23:0] a,
      input logic [1:0] c, input logic w);
      if (c == 2'b10) return a + (w ? 24'h2 : 24'h1);
      if (c == 2'b11) return a - (w ? 24'h2 : 24'h1);
      return a;
   endfunction
   initial
   begin
      #50000;
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (5) @(negedge clk);
      reset_n = 1;
      // ----------------------------------------
      // stepping codes, sizes, count and no irq
      // ----------------------------------------
      for (int k = 0; k < 6; k++)
      begin
         m = modes[k];
         u_mem.dmem[24'h1000] = 8'h50 + 8'(k);
         u_mem.dmem[24'h1001] = 8'ha5;
         u_mem.dmem[24'h2001] = 8'h00;
         load(16'hf800, {m, 24'h1000}, {8'h0, 24'h2000}, 32'h00050007);
         go(16'hf800);
         chk_set(16'hf800, {m, nxt(24'h1000, m[7:6], m[0])},
            {8'h0, nxt(24'h2000, m[5:4], m[0])}, 32'h00040007);
         check(u_mem.dmem[24'h2000], 8'h50 + 8'(k));
         check(u_mem.dmem[24'h2001], m[0] ? 8'ha5 : 8'h00);
         check(irq_n - n0, 0);
      end
      // out-of-window starts are refused
      go(16'hfc00);
      check(fault, 1'b1);
      go(16'hf7fc);
      check({fault, busy}, 2'b10);
      // irq after every transfer, or on reaching zero
      u_mem.dmem[24'h1000] = 8'h11;
      load(16'hf800, 32'ha0001000, 32'h40002000, 32'h00050000);
      go(16'hf800);
      check({fault, 8'(irq_n - n0)}, 9'h001);
      load(16'hf800, 32'ha0001000, 32'h00002000, 32'h00010000);
      go(16'hf800);
      check(irq_n - n0, 1);
      // chained sets run from one start
      load(16'hf840, 32'ha0001000, 32'h80002000, 32'h00050000);
      load(16'hf84c, 32'ha0001000, 32'h40003000, 32'h00050000);
      go(16'hf840);
      check(u_mem.info[8'h13], 32'ha0001001);
      check(u_mem.info[8'h15], 32'h00040000);
      check(u_mem.dmem[24'h3000], 8'h11);
      check(irq_n - n0, 1);
      // a chain pointer past the window stops with a fault and no irq
      load(16'hfbf4, 32'ha0001000, 32'h80002000, 32'h00050000);
      go(16'hfbf4);
      check({fault, 8'(irq_n - n0)}, 9'h100);
      // repeat mode reloads count and rewinds the repeat side
      load(16'hf800, 32'ha4001000, 32'h00002000, 32'h03010000);
      go(16'hf800);
      chk_set(16'hf800, 32'ha4001001, 32'h00002000, 32'h03030000);
      // block mode on either side, with a slow data bus
      u_mem.slow = 3;
      for (int s = 0; s < 2; s++)
      begin
         for (int i = 0; i < 6; i++) u_mem.dmem[24'h1000 + i] = 8'(8'h30 + i);
         m = {7'b1010100, 1'b1} | 8'(s << 1);
         load(16'hf800, {m, 24'h1000}, {8'h0, 24'h4000}, 32'h00030002);
         go(16'hf800);
         chk_set(16'hf800, {m, s ? 24'h1000 : 24'h1006},
            {8'h0, s ? 24'h4006 : 24'h4000}, 32'h00030001);
         for (int i = 0; i < 6; i++)
            check(u_mem.dmem[24'h4000 + i], 8'(8'h30 + i));
      end
      check(u_mem.bad_addr, 0);
      tally_and_finish();
   end
endmodule
